// file: logic/sam_coord_if.sv
// Coordinate path between the register core and the transform
`timescale 1ns/1ps
interface sam_coord_if;
    logic        in_valid;
    logic [11:0] sense_raw;
    logic [11:0] drive_raw;
    logic [2:0]  orient;
    logic        out_valid;
    logic [11:0] x;
    logic [11:0] y;
    modport core  (output in_valid, sense_raw, drive_raw, orient,
                   input  out_valid, x, y);
    modport xform (input  in_valid, sense_raw, drive_raw, orient,
                   output out_valid, x, y);
endinterface

// file: logic/sam_pkg.sv
// Constants shared by the sensor axis mapping block
package sam_pkg;
    localparam int          SAM_ID_W        = 6;
    localparam int          SAM_NUM_IDS     = 35;
    localparam int          SAM_RX_MAX      = 13;
    localparam int          SAM_TX_MAX      = 18;
    localparam int          SAM_CNT_W       = 5;
    localparam int          SAM_COORD_W     = 12;
    localparam logic [11:0] SAM_FULL_SCALE  = 12'hFFF;
    // Command codes
    localparam logic [7:0]  SAM_CMD_WRITE   = 8'h15;
    localparam logic [7:0]  SAM_CMD_READ    = 8'h16;
    // Register addresses
    localparam logic [7:0]  SAM_ADDR_RXMAP  = 8'h00;
    localparam logic [7:0]  SAM_ADDR_TXMAP  = 8'h20;
    localparam logic [7:0]  SAM_ADDR_RXCNT  = 8'h40;
    localparam logic [7:0]  SAM_ADDR_TXCNT  = 8'h41;
    localparam logic [7:0]  SAM_ADDR_RXSCL  = 8'h42;
    localparam logic [7:0]  SAM_ADDR_TXSCL  = 8'h43;
    localparam logic [7:0]  SAM_ADDR_ORIENT = 8'h44;
    // Reset values
    localparam logic [4:0]  SAM_RST_RXCNT   = 5'h0C;
    localparam logic [4:0]  SAM_RST_TXCNT   = 5'h09;
    localparam logic [15:0] SAM_RST_RXSCL   = 16'h1555;
    localparam logic [15:0] SAM_RST_TXSCL   = 16'h1C71;
    localparam logic [2:0]  SAM_RST_ORIENT  = 3'h1;
    // Orientation fields
    localparam int          SAM_OR_SWAP     = 2;
    localparam int          SAM_OR_TXINV    = 1;
    localparam int          SAM_OR_RXINV    = 0;
    // Configured-flag positions
    localparam int          SAM_CF_RXMAP    = 0;
    localparam int          SAM_CF_TXMAP    = 1;
    localparam int          SAM_CF_RXSCL    = 2;
    localparam int          SAM_CF_TXSCL    = 3;
    localparam int          SAM_CF_ORIENT   = 4;
    localparam logic [4:0]  SAM_CF_ALL      = 5'h1F;
endpackage

// file: logic/sam_top.sv
// Sensor axis mapping: pin maps, scaling, orientation
`timescale 1ns/1ps
module sam_top
    import sam_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    // Command port
    input  wire logic                    cmd_valid_i,
    input  wire logic [7:0]              cmd_code_i,
    input  wire logic [7:0]              cmd_addr_i,
    input  wire logic [15:0]             cmd_data_i,
    output logic                         rd_valid_o,
    output logic [15:0]                  rd_data_o,
    // Raw coordinates from acquisition
    input  wire logic                    raw_valid_i,
    input  wire logic [SAM_COORD_W-1:0]  sense_raw_i,
    input  wire logic [SAM_COORD_W-1:0]  drive_raw_i,
    // Oriented coordinates
    output logic                         coord_valid_o,
    output logic [SAM_COORD_W-1:0]       coord_x_o,
    output logic [SAM_COORD_W-1:0]       coord_y_o,
    // Configuration state
    output logic [15:0]                  rx_scale_o,
    output logic [15:0]                  tx_scale_o,
    output logic [SAM_NUM_IDS-1:0]       pin_gnd_o,
    output logic                         layout_valid_o
);
    typedef struct packed {
        logic [SAM_RX_MAX-1:0][SAM_ID_W-1:0] rx_map;
        logic [SAM_TX_MAX-1:0][SAM_ID_W-1:0] tx_map;
        logic [SAM_CNT_W-1:0]                rx_cnt;
        logic [SAM_CNT_W-1:0]                tx_cnt;
        logic [15:0]                         rx_scl;
        logic [15:0]                         tx_scl;
        logic [2:0]                          orient;
        logic [4:0]                          cfg;
        logic                                layout;
        logic [SAM_NUM_IDS-1:0]              gnd;
        logic                                rd_valid;
        logic [15:0]                         rd_data;
    } sam_state_type;

    sam_state_type          st_reg;
    sam_state_type          st_next;
    sam_state_type          st_rst;
    logic [SAM_NUM_IDS-1:0] used;
    logic                   wr;
    logic                   rd;
    sam_coord_if            cp ();

    assign wr = cmd_valid_i && cmd_code_i == SAM_CMD_WRITE;
    assign rd = cmd_valid_i && cmd_code_i == SAM_CMD_READ;

    ////////////////////////////////////////////////////////////////////
    // Reset image: default layout, identity map ids
    always_comb begin
        st_rst        = '0;
        for (int i = 0; i < SAM_RX_MAX; i++) begin
            st_rst.rx_map[i] = SAM_ID_W'(i);
        end
        for (int i = 0; i < SAM_TX_MAX; i++) begin
            st_rst.tx_map[i] = SAM_ID_W'(i + SAM_RX_MAX);
        end
        st_rst.rx_cnt = SAM_RST_RXCNT;
        st_rst.tx_cnt = SAM_RST_TXCNT;
        st_rst.rx_scl = SAM_RST_RXSCL;
        st_rst.tx_scl = SAM_RST_TXSCL;
        st_rst.orient = SAM_RST_ORIENT;
        st_rst.gnd    = '1;
    end

    ////////////////////////////////////////////////////////////////////
    // Pins used by the active map entries
    always_comb begin
        used = '0;
        for (int i = 0; i < SAM_RX_MAX; i++) begin
            if (SAM_CNT_W'(i) < st_reg.rx_cnt &&
                st_reg.rx_map[i] < SAM_ID_W'(SAM_NUM_IDS)) begin
                used[st_reg.rx_map[i]] = 1'b1;
            end
        end
        for (int i = 0; i < SAM_TX_MAX; i++) begin
            if (SAM_CNT_W'(i) < st_reg.tx_cnt &&
                st_reg.tx_map[i] < SAM_ID_W'(SAM_NUM_IDS)) begin
                used[st_reg.tx_map[i]] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command decode and register update
    always_comb begin
        st_next          = st_reg;
        st_next.gnd      = ~used;
        st_next.rd_valid = rd;
        if (wr) begin
            if (cmd_addr_i >= SAM_ADDR_RXMAP &&
                cmd_addr_i < SAM_ADDR_RXMAP + 8'(SAM_RX_MAX)) begin
                st_next.rx_map[4'(cmd_addr_i - SAM_ADDR_RXMAP)] =
                    cmd_data_i[SAM_ID_W-1:0];
                st_next.cfg[SAM_CF_RXMAP] = 1'b1;
            end
            if (cmd_addr_i >= SAM_ADDR_TXMAP &&
                cmd_addr_i < SAM_ADDR_TXMAP + 8'(SAM_TX_MAX)) begin
                st_next.tx_map[5'(cmd_addr_i - SAM_ADDR_TXMAP)] =
                    cmd_data_i[SAM_ID_W-1:0];
                st_next.cfg[SAM_CF_TXMAP] = 1'b1;
            end
            unique case (cmd_addr_i)
                SAM_ADDR_RXCNT: begin
                    st_next.rx_cnt = cmd_data_i[SAM_CNT_W-1:0];
                end
                SAM_ADDR_TXCNT: begin
                    st_next.tx_cnt = cmd_data_i[SAM_CNT_W-1:0];
                end
                SAM_ADDR_RXSCL: begin
                    st_next.rx_scl            = cmd_data_i;
                    st_next.cfg[SAM_CF_RXSCL] = 1'b1;
                end
                SAM_ADDR_TXSCL: begin
                    st_next.tx_scl            = cmd_data_i;
                    st_next.cfg[SAM_CF_TXSCL] = 1'b1;
                end
                SAM_ADDR_ORIENT: begin
                    st_next.orient             = cmd_data_i[2:0];
                    st_next.cfg[SAM_CF_ORIENT] = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            st_next.rd_data = 16'h0000;
            if (cmd_addr_i >= SAM_ADDR_RXMAP &&
                cmd_addr_i < SAM_ADDR_RXMAP + 8'(SAM_RX_MAX)) begin
                st_next.rd_data[SAM_ID_W-1:0] =
                    st_reg.rx_map[4'(cmd_addr_i - SAM_ADDR_RXMAP)];
            end
            if (cmd_addr_i >= SAM_ADDR_TXMAP &&
                cmd_addr_i < SAM_ADDR_TXMAP + 8'(SAM_TX_MAX)) begin
                st_next.rd_data[SAM_ID_W-1:0] =
                    st_reg.tx_map[5'(cmd_addr_i - SAM_ADDR_TXMAP)];
            end
            unique case (cmd_addr_i)
                SAM_ADDR_RXCNT: begin
                    st_next.rd_data[SAM_CNT_W-1:0] = st_reg.rx_cnt;
                end
                SAM_ADDR_TXCNT: begin
                    st_next.rd_data[SAM_CNT_W-1:0] = st_reg.tx_cnt;
                end
                SAM_ADDR_RXSCL: begin
                    st_next.rd_data = st_reg.rx_scl;
                end
                SAM_ADDR_TXSCL: begin
                    st_next.rd_data = st_reg.tx_scl;
                end
                SAM_ADDR_ORIENT: begin
                    st_next.rd_data[2:0] = st_reg.orient;
                end
                default: begin
                end
            endcase
        end
        st_next.layout = st_next.cfg == SAM_CF_ALL;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_reg <= st_rst;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Orientation applied to each coordinate as it arrives
    assign cp.in_valid  = raw_valid_i;
    assign cp.sense_raw = sense_raw_i;
    assign cp.drive_raw = drive_raw_i;
    assign cp.orient    = st_reg.orient;

    sam_xform u_xform (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .cp        (cp)
    );

    assign coord_valid_o  = cp.out_valid;
    assign coord_x_o      = cp.x;
    assign coord_y_o      = cp.y;
    assign rd_valid_o     = st_reg.rd_valid;
    assign rd_data_o      = st_reg.rd_data;
    assign rx_scale_o     = st_reg.rx_scl;
    assign tx_scale_o     = st_reg.tx_scl;
    assign pin_gnd_o      = st_reg.gnd;
    assign layout_valid_o = st_reg.layout;

    ////////////////////////////////////////////////////////////////////
    sequence s_orient_write;
        wr && cmd_addr_i == SAM_ADDR_ORIENT;
    endsequence

    sequence s_orient_read;
        rd && cmd_addr_i == SAM_ADDR_ORIENT;
    endsequence

    property p_orient_store;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_orient_write |=> cp.orient == $past(cmd_data_i[2:0]);
    endproperty
    a_orient_store: assert property (p_orient_store)
        else $error("orientation write not stored");

    property p_orient_rsvd;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_orient_read |=> rd_valid_o && rd_data_o[15:3] == 13'h0000;
    endproperty
    a_orient_rsvd: assert property (p_orient_rsvd)
        else $error("unimplemented orientation bits read nonzero");

    property p_default_layout;
        @(posedge mclk_i)
        !reset_n_i ##1 reset_n_i |-> st_reg.rx_cnt == SAM_RST_RXCNT &&
            st_reg.tx_cnt == SAM_RST_TXCNT && cp.orient == SAM_RST_ORIENT;
    endproperty
    a_default_layout: assert property (p_default_layout)
        else $error("power-up layout not the default");

    property p_scale_store;
        @(posedge mclk_i) disable iff (!reset_n_i)
        wr && cmd_addr_i == SAM_ADDR_TXSCL
        |=> tx_scale_o == $past(cmd_data_i) && rx_scale_o == $past(rx_scale_o);
    endproperty
    a_scale_store: assert property (p_scale_store)
        else $error("drive scale write not kept separate");

    property p_used_not_gnd;
        @(posedge mclk_i) disable iff (!reset_n_i)
        reset_n_i && !cmd_valid_i ##1 !cmd_valid_i
        |-> !pin_gnd_o[$past(st_reg.rx_map[0])];
    endproperty
    a_used_not_gnd: assert property (p_used_not_gnd)
        else $error("mapped sense pin driven to ground");

    property p_layout_valid;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $rose(layout_valid_o) |-> $past(wr);
    endproperty
    a_layout_valid: assert property (p_layout_valid)
        else $error("layout valid without a register write");

    property p_orient_live;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_orient_write ##[1:3] raw_valid_i
        |=> coord_valid_o &&
            (cp.orient[SAM_OR_SWAP] ? coord_x_o : coord_y_o) ==
            ($past(sense_raw_i) ^ {SAM_COORD_W{cp.orient[SAM_OR_RXINV]}});
    endproperty
    a_orient_live: assert property (p_orient_live)
        else $error("coordinate dropped after orientation change");
endmodule

// file: logic/sam_xform.sv
// Swap and invert of raw axis coordinates
`timescale 1ns/1ps
module sam_xform
    import sam_pkg::*;
(
    // Clock and reset
    input  wire logic   mclk_i,
    input  wire logic   reset_n_i,
    // Coordinate path
    sam_coord_if.xform  cp
);
    typedef struct packed {
        logic        out_valid;
        logic [11:0] x;
        logic [11:0] y;
    } sam_xf_state_type;

    sam_xf_state_type st_reg;
    sam_xf_state_type st_next;
    logic [11:0]      s_val;
    logic [11:0]      d_val;

    always_comb begin
        st_next           = st_reg;
        st_next.out_valid = cp.in_valid;
        s_val = cp.orient[SAM_OR_RXINV] ?
                SAM_FULL_SCALE - cp.sense_raw : cp.sense_raw;
        d_val = cp.orient[SAM_OR_TXINV] ?
                SAM_FULL_SCALE - cp.drive_raw : cp.drive_raw;
        if (cp.in_valid) begin
            if (cp.orient[SAM_OR_SWAP]) begin
                st_next.x = s_val;
                st_next.y = d_val;
            end else begin
                st_next.x = d_val;
                st_next.y = s_val;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cp.out_valid = st_reg.out_valid;
    assign cp.x         = st_reg.x;
    assign cp.y         = st_reg.y;

    ////////////////////////////////////////////////////////////////////
    property p_swap_sense_x;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cp.in_valid && cp.orient == 3'h4 |=> cp.x == $past(cp.sense_raw);
    endproperty
    a_swap_sense_x: assert property (p_swap_sense_x)
        else $error("sense axis not horizontal under swap");

    property p_rx_invert;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cp.in_valid && cp.orient == 3'h1
        |=> cp.y == SAM_FULL_SCALE - $past(cp.sense_raw);
    endproperty
    a_rx_invert: assert property (p_rx_invert)
        else $error("sense axis not inverted");

    property p_tx_invert;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cp.in_valid && cp.orient == 3'h6
        |=> cp.y == SAM_FULL_SCALE - $past(cp.drive_raw);
    endproperty
    a_tx_invert: assert property (p_tx_invert)
        else $error("drive axis not inverted after swap");

    property p_plain;
        @(posedge mclk_i) disable iff (!reset_n_i)
        cp.in_valid && cp.orient == 3'h0
        |=> cp.x == $past(cp.drive_raw) && cp.y == $past(cp.sense_raw);
    endproperty
    a_plain: assert property (p_plain)
        else $error("plain orientation altered coordinates");
endmodule

// file: tb/sam_grid_model.sv
// Behavioural sensor grid that reports raw axis positions
`timescale 1ns/1ps
module sam_grid_model
    import sam_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    // Touch request from the bench
    input  wire logic                    touch_i,
    input  wire logic [SAM_COORD_W-1:0]  sense_pos_i,
    input  wire logic [SAM_COORD_W-1:0]  drive_pos_i,
    // Raw coordinates to the block
    output logic                         raw_valid_o,
    output logic [SAM_COORD_W-1:0]       sense_raw_o,
    output logic [SAM_COORD_W-1:0]       drive_raw_o
);
    // One strobe per touch; stale values toggle between reports
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            raw_valid_o <= 1'b0;
            sense_raw_o <= 12'hA5A;
            drive_raw_o <= 12'h5A5;
        end else if (touch_i) begin
            raw_valid_o <= 1'b1;
            sense_raw_o <= sense_pos_i;
            drive_raw_o <= drive_pos_i;
        end else begin
            raw_valid_o <= 1'b0;
            sense_raw_o <= ~sense_raw_o;
            drive_raw_o <= ~drive_raw_o;
        end
    end
endmodule

// file: tb/sam_top_bench.sv
// Self-checking bench for the sensor axis mapping block
`timescale 1ns/1ps
module sam_top_bench;
    import sam_pkg::*;
    logic        mclk_i, reset_n_i, cmd_valid_i, rd_valid_o, raw_valid_i;
    logic        coord_valid_o, layout_valid_o, touch;
    logic [7:0]  cmd_code_i, cmd_addr_i;
    logic [15:0] cmd_data_i, rd_data_o, rx_scale_o, tx_scale_o;
    logic [11:0] sense_raw_i, drive_raw_i, coord_x_o, coord_y_o;
    logic [11:0] sense_pos, drive_pos;
    logic [34:0] pin_gnd_o;
    int          fails, comparisons;

    sam_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .raw_valid_i(raw_valid_i), .sense_raw_i(sense_raw_i),
        .drive_raw_i(drive_raw_i), .coord_valid_o(coord_valid_o),
        .coord_x_o(coord_x_o), .coord_y_o(coord_y_o),
        .rx_scale_o(rx_scale_o), .tx_scale_o(tx_scale_o),
        .pin_gnd_o(pin_gnd_o), .layout_valid_o(layout_valid_o));

    sam_grid_model GRID (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .touch_i(touch), .sense_pos_i(sense_pos), .drive_pos_i(drive_pos),
        .raw_valid_o(raw_valid_i), .sense_raw_o(sense_raw_i),
        .drive_raw_o(drive_raw_i));

    ////////////////////////////////////////////////////////////////////////
    // Compare, command and report tasks
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_coord(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t x/y %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pins(input logic [34:0] got, input logic [34:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t ground mask %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] code, input logic [7:0] addr,
                        input logic [15:0] data);
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_code_i  <= code;
        cmd_addr_i  <= addr;
        cmd_data_i  <= data;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        #1;
    endtask
    task automatic read_chk(input logic [7:0] addr, input logic [15:0] exp);
        send(SAM_CMD_READ, addr, 16'h0000);
        chk_reg({15'h0000, rd_valid_o}, 16'h0001);
        chk_reg(rd_data_o, exp);
    endtask
    task automatic touch_chk(input logic [11:0] sp, input logic [11:0] dp,
                             input logic [11:0] ex, input logic [11:0] ey);
        int n;
        n = 0;
        @(posedge mclk_i);
        touch     <= 1'b1;
        sense_pos <= sp;
        drive_pos <= dp;
        @(posedge mclk_i);
        touch <= 1'b0;
        #1;
        while (coord_valid_o !== 1'b1 && n < 10) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk_reg({15'h0000, coord_valid_o}, 16'h0001);
        chk_coord({coord_x_o, coord_y_o}, {ex, ey});
    endtask
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [34:0] exp;
        exp = '1;
        for (int i = 0; i < 22; i++) begin
            if (i != 12) exp[i] = 1'b0;
        end
        repeat (3) @(posedge mclk_i);
        #1;
        chk_reg(rx_scale_o, 16'h1555);
        chk_reg(tx_scale_o, 16'h1C71);
        chk_pins(pin_gnd_o, exp);
        chk_reg({15'h0000, layout_valid_o}, 16'h0000);
        read_chk(SAM_ADDR_ORIENT, 16'h0001);
    endtask
    task automatic t_scale();
        logic [15:0] tbl [3];
        tbl = '{16'h5555, 16'h1000, 16'h0E38};
        for (int i = 0; i < 3; i++) begin
            send(SAM_CMD_WRITE, SAM_ADDR_RXSCL, tbl[i]);
            send(SAM_CMD_WRITE, SAM_ADDR_TXSCL, tbl[2-i]);
            chk_reg(rx_scale_o, tbl[i]);
            chk_reg(tx_scale_o, tbl[2-i]);
            read_chk(SAM_ADDR_TXSCL, tbl[2-i]);
            read_chk(SAM_ADDR_RXSCL, tbl[i]);
        end
    endtask
    task automatic t_maps();
        logic [5:0]  rxm [4];
        logic [5:0]  txm [11];
        logic [34:0] exp;
        rxm = '{6'h03, 6'h02, 6'h01, 6'h00};
        txm = '{6'h0F, 6'h10, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h16, 6'h08,
                6'h05, 6'h17, 6'h18};
        exp = '1;
        send(SAM_CMD_WRITE, SAM_ADDR_RXCNT, 16'h0004);
        send(SAM_CMD_WRITE, SAM_ADDR_TXCNT, 16'h000B);
        read_chk(SAM_ADDR_RXCNT, 16'h0004);
        read_chk(SAM_ADDR_TXCNT, 16'h000B);
        // No shared pin, edge sense pins kept off drive lines
        for (int i = 0; i < 4; i++) begin
            send(SAM_CMD_WRITE, SAM_ADDR_RXMAP + 8'(i), 16'(rxm[i]));
            exp[rxm[i]] = 1'b0;
        end
        for (int i = 0; i < 11; i++) begin
            send(SAM_CMD_WRITE, SAM_ADDR_TXMAP + 8'(i), 16'(txm[i]));
            exp[txm[i]] = 1'b0;
        end
        repeat (3) @(posedge mclk_i);
        #1;
        chk_pins(pin_gnd_o, exp);
        read_chk(SAM_ADDR_TXMAP + 8'h06, 16'h0016);
        read_chk(SAM_ADDR_RXMAP + 8'h00, 16'h0003);
        chk_reg({15'h0000, layout_valid_o}, 16'h0000);
    endtask
    task automatic t_orient();
        logic [11:0] s, d;
        for (int v = 0; v < 8; v++) begin
            send(SAM_CMD_WRITE, SAM_ADDR_ORIENT, 16'h00F8 | 16'(v));
            s = v[0] ? SAM_FULL_SCALE - 12'h123 : 12'h123;
            d = v[1] ? SAM_FULL_SCALE - 12'h456 : 12'h456;
            if (v[2]) touch_chk(12'h123, 12'h456, s, d);
            else touch_chk(12'h123, 12'h456, d, s);
            read_chk(SAM_ADDR_ORIENT, 16'(v));
        end
        chk_reg({15'h0000, layout_valid_o}, 16'h0001);
    endtask
    task automatic t_refuse();
        send(8'h17, SAM_ADDR_ORIENT, 16'h0000);
        read_chk(SAM_ADDR_ORIENT, 16'h0007);
        send(SAM_CMD_WRITE, 8'h50, 16'hBEEF);
        read_chk(8'h50, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset, sequence and watchdog
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    initial begin
        reset_n_i   = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_code_i  = 8'h00;
        cmd_addr_i  = 8'h00;
        cmd_data_i  = 16'h0000;
        touch       = 1'b0;
        sense_pos   = 12'h000;
        drive_pos   = 12'h000;
        fails       = 0;
        comparisons = 0;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_scale();
        t_maps();
        t_orient();
        t_refuse();
        summarize();
    end
    initial begin
        #100000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule
